// ---- hw/dcc_pkg.sv ----
// Constants, register map and state types of the dual capture/compare unit
package dcc_pkg;

    // ****************************************
    // Register indices (byte address = 4 * index)
    // ****************************************
    localparam logic [5:0] IDX_CH1_LOW = 6'h15;
    localparam logic [5:0] IDX_CH1_HIGH = 6'h16;
    localparam logic [5:0] IDX_CH1_CTL = 6'h17;
    localparam logic [5:0] IDX_CH2_LOW = 6'h1B;
    localparam logic [5:0] IDX_CH2_HIGH = 6'h1C;
    localparam logic [5:0] IDX_CH2_CTL = 6'h1D;
    localparam logic [5:0] IDX_FLAGS = 6'h20;
    localparam int IDX_LSB = 2;

    // ****************************************
    // Control field layout and mode codes
    // ****************************************
    localparam int CTL_DUTY_HI_BIT = 5;
    localparam int CTL_DUTY_LO_BIT = 4;
    localparam logic [3:0] MODE_OFF = 4'h0;
    localparam logic [3:0] MODE_CAP_FALL = 4'h4;
    localparam logic [3:0] MODE_CAP_RISE = 4'h5;
    localparam logic [3:0] MODE_CAP_4 = 4'h6;
    localparam logic [3:0] MODE_CAP_16 = 4'h7;
    localparam logic [3:0] MODE_CMP_SET = 4'h8;
    localparam logic [3:0] MODE_CMP_CLR = 4'h9;
    localparam logic [3:0] MODE_CMP_SW = 4'hA;
    localparam logic [3:0] MODE_CMP_SPEC = 4'hB;
    localparam logic [1:0] GRP_CAP = 2'h1;
    localparam logic [1:0] GRP_CMP = 2'h2;
    localparam logic [1:0] GRP_PWM = 2'h3;

    // ****************************************
    // Reset values and prescaler terminal counts
    // ****************************************
    localparam logic [5:0] CTL_RESET = 6'h00;
    localparam logic [15:0] VAL_RESET = 16'h0000;
    localparam logic [3:0] PSC_RESET = 4'h0;
    localparam logic [3:0] PSC_LAST_16 = 4'hF;
    localparam logic [1:0] PSC_LAST_4 = 2'h3;

    // Timebase inputs from the shared timers
    typedef struct packed {
        logic [15:0] wide_count;
        logic [7:0] period_count;
        logic [1:0] period_fine;
        logic period_end;
    } dcc_tb_t;

    // Per channel state
    typedef struct packed {
        logic [5:0] ctl;
        logic [15:0] val;
        logic [3:0] psc;
        logic [1:0] duty_lat;
        logic out;
        logic flag;
        logic match_prev;
        logic s1;
        logic s2;
        logic prev;
    } dcc_ch_t;

    // Whole block state
    typedef struct packed {
        dcc_ch_t [1:0] ch;
        logic ack;
        logic [31:0] rdata;
        logic tb_clear;
        logic adc_go;
    } dcc_state_t;

endpackage

// ---- hw/dcc_unit.sv ----
// Two capture/compare/PWM channels with an Avalon-MM register slave
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ns

// Behaviour
// (RULE1) Each channel has a 16-bit value in low/high bytes plus control, all accessible.
// (RULE2) Mode 0000 turns the channel off and resets its internal state.
// (RULE3) Modes 0100-0111 capture on fall, rise, every 4th or every 16th rise.
// (RULE4) Mode 1000 sets, 1001 clears the pin on match; both set the flag.
// (RULE5) Mode 1010 only sets the flag on match; pin stays unchanged.
// (RULE6) Mode 1011 sets flag and clears the wide timebase; channel two also starts ADC.
// (RULE7) Modes 11xx are PWM; duty is low byte plus control bits 5:4.
// (RULE8) Control bits 7:6 read zero; duty bits do nothing outside PWM.
// (RULE9) A capture copies the full 16-bit timebase into the value register.
// (RULE10) Every capture sets the flag; only software clears it.
// (RULE11) A new capture overwrites the value even if unread.
// (RULE12) Pin is sampled as is, so a port write on an output can capture.
// (RULE13) Software runs the wide timebase synchronously for capture or compare.
// (RULE14) Software masks the interrupt around mode changes and clears the flag.
// (RULE15) Prescaler counter is cleared when off or outside capture modes.
// (RULE16) Capture-to-capture mode change keeps the prescaler count.
// (RULE17) Compare matches value against timebase; pin action and flag together.
// (RULE18) Writing zero to control forces the compare output latch low.
// (RULE19) Software makes the pin an output for compare; the unit drives the pin itself whenever control bit 3 is set.
// (RULE20) Capture/compare use the wide timebase, PWM the period timebase.
// (RULE21) Comparing channels should use the special event mode.
// (RULE22) Channel two equals channel one except its event also starts ADC.
// (RULE23) Special event timebase clear does not set the overflow flag.
// (RULE24) Pin is synchronised before edge detection; capture latency is fixed.
module dcc_unit import dcc_pkg::*; #(
    parameter int ADDR_W = 8
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire dcc_tb_t tb,
    input wire logic adc_enable,
    input wire logic [1:0] pin_in,
    output logic [1:0] pin_out,
    output logic [1:0] pin_oe_n,
    output logic [1:0] irq_flag,
    output logic wide_timebase_clear,
    output logic adc_start
);

    // Register index needs bits up to the flags register
    if (ADDR_W < 8) begin : g_chk
        $error("dcc_unit: ADDR_W must be at least 8");
    end

    dcc_state_t r, n;
    logic [1:0] cap_ev, cmp_ev, rise, fall, match;
    logic [3:0] md [2];
    logic [5:0] idx;
    logic acc, wr_ok, rd_ok;
    logic [31:0] rd_val;

    // ****************************************
    // Bus decode
    // ****************************************
    assign idx = address[IDX_LSB +: 6];
    assign acc = read | write;
    assign waitrequest = acc & ~r.ack;
    assign wr_ok = write & r.ack & byteenable[0];
    assign rd_ok = read & ~r.ack;
    assign readdata = r.rdata;

    // Read multiplexer, unmapped reads return zero
    always_comb begin
        unique case (idx)
            IDX_CH1_LOW: rd_val = {24'h000000, r.ch[0].val[7:0]}; // RULE1
            IDX_CH1_HIGH: rd_val = {24'h000000, r.ch[0].val[15:8]};
            IDX_CH1_CTL: rd_val = {26'h0000000, r.ch[0].ctl}; // RULE8
            IDX_CH2_LOW: rd_val = {24'h000000, r.ch[1].val[7:0]};
            IDX_CH2_HIGH: rd_val = {24'h000000, r.ch[1].val[15:8]};
            IDX_CH2_CTL: rd_val = {26'h0000000, r.ch[1].ctl};
            IDX_FLAGS: rd_val = {30'h00000000, r.ch[1].flag, r.ch[0].flag};
            default: rd_val = 32'h00000000;
        endcase
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        n = r;
        n.ack = acc & ~r.ack;
        n.tb_clear = 1'b0;
        n.adc_go = 1'b0;
        if (rd_ok) begin
            n.rdata = rd_val;
        end
        for (int i = 0; i < 2; i++) begin
            md[i] = r.ch[i].ctl[3:0];
            // Two-stage synchroniser, then an edge stage
            n.ch[i].s1 = pin_in[i]; // RULE24 RULE12
            n.ch[i].s2 = r.ch[i].s1;
            n.ch[i].prev = r.ch[i].s2;
            rise[i] = r.ch[i].s2 & ~r.ch[i].prev;
            fall[i] = ~r.ch[i].s2 & r.ch[i].prev;

            // Edge prescaler, kept across capture modes
            if (md[i][3:2] != GRP_CAP) begin
                n.ch[i].psc = PSC_RESET; // RULE15
            end else if (rise[i]) begin
                n.ch[i].psc = 4'(r.ch[i].psc + 4'h1); // RULE16
            end

            // Capture event selection
            unique case (md[i])
                MODE_CAP_FALL: cap_ev[i] = fall[i]; // RULE3
                MODE_CAP_RISE: cap_ev[i] = rise[i];
                MODE_CAP_4: cap_ev[i] = rise[i] && r.ch[i].psc[1:0] == PSC_LAST_4;
                MODE_CAP_16: cap_ev[i] = rise[i] && r.ch[i].psc == PSC_LAST_16;
                default: cap_ev[i] = 1'b0;
            endcase

            // Compare against the wide timebase, one event per match
            match[i] = r.ch[i].val == tb.wide_count; // RULE17 RULE20
            n.ch[i].match_prev = match[i];
            cmp_ev[i] = md[i][3:2] == GRP_CMP && match[i] && !r.ch[i].match_prev;

            // Software writes to the channel registers
            if (wr_ok && idx == (i == 0 ? IDX_CH1_CTL : IDX_CH2_CTL)) begin
                n.ch[i].ctl = writedata[5:0]; // RULE1
            end
            if (wr_ok && idx == (i == 0 ? IDX_CH1_LOW : IDX_CH2_LOW)) begin
                n.ch[i].val[7:0] = writedata[7:0];
            end
            // High byte is read only in PWM, it holds the live duty
            if (wr_ok && idx == (i == 0 ? IDX_CH1_HIGH : IDX_CH2_HIGH)
                && md[i][3:2] != GRP_PWM) begin
                n.ch[i].val[15:8] = writedata[7:0];
            end

            // Capture wins over a software write in the same cycle
            if (cap_ev[i]) begin
                n.ch[i].val = tb.wide_count; // RULE9 RULE11
            end

            // Flag: write one to clear, a new event wins over the clear
            if (wr_ok && idx == IDX_FLAGS && writedata[i]) begin
                n.ch[i].flag = 1'b0;
            end
            if (cap_ev[i] || cmp_ev[i]) begin
                n.ch[i].flag = 1'b1; // RULE10 RULE4 RULE5
            end

            // Compare pin action
            if (cmp_ev[i] && md[i] == MODE_CMP_SET) begin
                n.ch[i].out = 1'b1; // RULE4
            end
            if (cmp_ev[i] && md[i] == MODE_CMP_CLR) begin
                n.ch[i].out = 1'b0;
            end

            // Special event, the overflow flag of the timebase is not touched
            if (cmp_ev[i] && md[i] == MODE_CMP_SPEC) begin
                n.tb_clear = 1'b1; // RULE6 RULE23
                if (i == 1 && adc_enable) begin
                    n.adc_go = 1'b1; // RULE22
                end
            end

            // PWM: clear at the duty point, then reload at period end and set if the new duty is nonzero
            if (md[i][3:2] == GRP_PWM) begin
                if ({tb.period_count, tb.period_fine}
                    == {r.ch[i].val[15:8], r.ch[i].duty_lat}) begin
                    n.ch[i].out = 1'b0; // RULE20
                end
                if (tb.period_end) begin
                    n.ch[i].val[15:8] = r.ch[i].val[7:0]; // RULE7
                    n.ch[i].duty_lat = r.ch[i].ctl[CTL_DUTY_HI_BIT:CTL_DUTY_LO_BIT];
                    n.ch[i].out = {r.ch[i].val[7:0],
                        r.ch[i].ctl[CTL_DUTY_HI_BIT:CTL_DUTY_LO_BIT]} != 10'h000;
                end
            end

            // Off: output latch low and internal state cleared
            if (md[i] == MODE_OFF) begin
                n.ch[i].out = 1'b0; // RULE2 RULE18
                n.ch[i].duty_lat = 2'h0;
                n.ch[i].match_prev = 1'b0;
            end
        end
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            r <= '0;
            r.ch[0].ctl <= CTL_RESET;
            r.ch[1].ctl <= CTL_RESET;
            r.ch[0].val <= VAL_RESET;
            r.ch[1].val <= VAL_RESET;
        end else begin
            r <= n;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    for (genvar g = 0; g < 2; g++) begin : g_out
        assign pin_out[g] = r.ch[g].out;
        assign pin_oe_n[g] = !(r.ch[g].ctl[3]); // Drive in compare and PWM
        assign irq_flag[g] = r.ch[g].flag;
    end
    assign wide_timebase_clear = r.tb_clear;
    assign adc_start = r.adc_go;

    // ****************************************
    // Assertions
    // ****************************************
    sequence flags_write_s;
        wr_ok && idx == IDX_FLAGS;
    endsequence

    for (genvar g = 0; g < 2; g++) begin : g_chk_ch
        sequence rise_in_mode_s(logic [3:0] m);
            r.ch[g].ctl[3:0] == m && r.ch[g].s2 && !r.ch[g].prev;
        endsequence
        sequence match_in_mode_s(logic [3:0] m);
            r.ch[g].ctl[3:0] == m && r.ch[g].val == tb.wide_count && !r.ch[g].match_prev;
        endsequence

        off_state_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE2
            r.ch[g].ctl[3:0] == MODE_OFF ##1 r.ch[g].ctl[3:0] == MODE_OFF
            |-> !pin_out[g] && r.ch[g].psc == PSC_RESET)
            else $error("off channel keeps state");
        cap_rise_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE9
            rise_in_mode_s(MODE_CAP_RISE)
            |=> r.ch[g].val == $past(tb.wide_count) && irq_flag[g])
            else $error("rising capture missed");
        cap_sixteen_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE3
            rise_in_mode_s(MODE_CAP_16) ##0 (r.ch[g].psc != PSC_LAST_16 && !wr_ok)
            |=> r.ch[g].val == $past(r.ch[g].val))
            else $error("capture before sixteenth edge");
        cmp_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE4
            match_in_mode_s(MODE_CMP_SET) |=> pin_out[g] && irq_flag[g])
            else $error("compare set failed");
        cmp_clr_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE17
            match_in_mode_s(MODE_CMP_CLR) |=> !pin_out[g] && irq_flag[g])
            else $error("compare clear failed");
        cmp_soft_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE5
            match_in_mode_s(MODE_CMP_SW) |=> $stable(pin_out[g]) && irq_flag[g])
            else $error("software compare moved pin");
        spec_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE6
            match_in_mode_s(MODE_CMP_SPEC) |=> wide_timebase_clear ##1 !wide_timebase_clear
                || r.ch[0].ctl[3:0] == MODE_CMP_SPEC || r.ch[1].ctl[3:0] == MODE_CMP_SPEC)
            else $error("special event did not clear timebase");
        flag_sticky_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE10
            irq_flag[g] && !(wr_ok && idx == IDX_FLAGS) |=> irq_flag[g])
            else $error("flag cleared by hardware");
    end

    adc_go_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE22
        adc_start |-> $past(cmp_ev[1]) && $past(adc_enable) && wide_timebase_clear)
        else $error("conversion start without event");
    ctl_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE8
        rd_ok && (idx == IDX_CH1_CTL || idx == IDX_CH2_CTL) |=> readdata[31:6] == 26'h0000000)
        else $error("unimplemented control bits read nonzero");

endmodule

// ---- test/dcc_pin_model.sv ----
// Pin model: external edge source and driven load on both channel pins
`timescale 1ns/1ns
module dcc_pin_model import dcc_pkg::*; (
    input wire logic ref_clk,
    input wire logic [1:0] ext_lvl,
    input wire logic [1:0] pin_out,
    input wire logic [1:0] pin_oe_n,
    output logic [1:0] pin_in
);
    logic [1:0] src_r;
    // Source lags its request by one clock, like a slow external driver
    always_ff @(posedge ref_clk) begin
        src_r <= ext_lvl;
    end
    // Wire level: channel latch while it drives, external source otherwise
    assign pin_in = (pin_oe_n & src_r) | (~pin_oe_n & pin_out);
endmodule

// ---- test/dcc_unit_bench.sv ----
// Self-checking testbench for the dual capture/compare unit
`timescale 1ns/1ns
module dcc_unit_bench import dcc_pkg::*;;
    logic ref_clk, rst_n, read, write, waitrequest, adc_enable, wtc, adc_go;
    logic [7:0] address;
    logic [31:0] writedata, readdata, q;
    logic [3:0] byteenable;
    logic [1:0] pin_in, pin_out, pin_oe_n, irq_flag, ext_lvl;
    dcc_tb_t tbv;
    int fails, total_checks, clr_n, adc_n, c0, a0;
    logic [5:0] lo [2] = '{IDX_CH1_LOW, IDX_CH2_LOW};
    logic [5:0] hi [2] = '{IDX_CH1_HIGH, IDX_CH2_HIGH};
    logic [5:0] ctl [2] = '{IDX_CH1_CTL, IDX_CH2_CTL};
    logic [3:0] cm [5] = '{MODE_CMP_SET, MODE_CMP_SW, MODE_CMP_CLR, MODE_CMP_SPEC, MODE_CMP_SET};
    logic cp [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};

    dcc_unit dcc_unit_inst (.ref_clk(ref_clk), .rst_n(rst_n), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .tb(tbv), .adc_enable(adc_enable), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .irq_flag(irq_flag),
        .wide_timebase_clear(wtc), .adc_start(adc_go));
    dcc_pin_model dcc_pin_model_inst (.ref_clk(ref_clk), .ext_lvl(ext_lvl), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .pin_in(pin_in));

    // ****************************************
    // Clock, pulse counters and hang guard
    // ****************************************
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Count one-cycle event pulses
    always @(posedge ref_clk) begin
        if (wtc === 1'b1) clr_n++;
        if (adc_go === 1'b1) adc_n++;
    end
    initial begin
        repeat (100000) @(posedge ref_clk);
        fails++;
        close_out();
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task close_out;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One Avalon access; read data land in q
    task acc(input logic wr, input logic [5:0] idx, input logic [7:0] d);
        int n;
        logic done;
        n = 0;
        @(posedge ref_clk);
        address <= {idx, 2'b00};
        read <= ~wr;
        write <= wr;
        writedata <= {24'h000000, d};
        do begin
            @(posedge ref_clk);
            n++;
            done = (waitrequest === 1'b0);
            q = readdata;
        end while (!done && n < 50);
        read <= 1'b0;
        write <= 1'b0;
        if (!done) begin
            fails++;
            close_out();
        end
    endtask
    task chkval(input int ch, input logic [15:0] exp);
        acc(1'b0, lo[ch], 8'h00);
        chk("value low", {24'h000000, exp[7:0]}, q);
        acc(1'b0, hi[ch], 8'h00);
        chk("value high", {24'h000000, exp[15:8]}, q);
    endtask
    task pin(input int ch, input logic v);
        @(posedge ref_clk);
        ext_lvl[ch] <= v;
        repeat (6) @(posedge ref_clk);
    endtask
    // Timebase moves on the block clock only, loaded with a value by the test
    task setw(input logic [15:0] v);
        @(posedge ref_clk);
        tbv.wide_count <= v;
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        rst_n = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = 8'h00;
        writedata = 32'h00000000;
        byteenable = 4'hF;
        tbv = '0;
        adc_enable = 1'b1;
        ext_lvl = 2'h0;
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        acc(1'b0, 6'h3F, 8'h00);
        chk("unmapped read", 32'h00000000, q);
        for (int ch = 0; ch < 2; ch++) begin
            // Register reset value, unimplemented bits and byte access
            acc(1'b0, ctl[ch], 8'h00);
            chk("control reset", 32'h00000000, q);
            acc(1'b1, ctl[ch], 8'hF0);
            acc(1'b0, ctl[ch], 8'h00);
            chk("control readback", 32'h00000030, q);
            acc(1'b1, lo[ch], 8'h5A);
            acc(1'b1, hi[ch], 8'hC3);
            chkval(ch, 16'hC35A);
            // Rising edge capture, falling ignored, overwrite
            acc(1'b1, ctl[ch], {4'h0, MODE_CAP_RISE});
            acc(1'b1, IDX_FLAGS, 8'h03);
            setw(16'hA5C3);
            pin(ch, 1'b1);
            chkval(ch, 16'hA5C3);
            chk("capture flag", 32'h1, {31'h0, irq_flag[ch]});
            setw(16'h0F1E);
            pin(ch, 1'b0);
            chkval(ch, 16'hA5C3);
            pin(ch, 1'b1);
            chkval(ch, 16'h0F1E);
            chk("flag sticky", 32'h1, {31'h0, irq_flag[ch]});
            acc(1'b1, IDX_FLAGS, 8'h03);
            @(posedge ref_clk);
            chk("flag cleared", 32'h0, {31'h0, irq_flag[ch]});
            // Falling edge capture
            acc(1'b1, ctl[ch], {4'h0, MODE_CAP_FALL});
            setw(16'h7788);
            pin(ch, 1'b0);
            chkval(ch, 16'h7788);
            // Every 4th and every 16th rise, restarted through mode off
            for (int k = 0; k < 2; k++) begin
                acc(1'b1, ctl[ch], 8'h00);
                acc(1'b1, ctl[ch], {4'h0, (k == 1) ? MODE_CAP_16 : MODE_CAP_4});
                acc(1'b1, IDX_FLAGS, 8'h03);
                repeat ((k == 1) ? 15 : 3) begin
                    pin(ch, 1'b1);
                    pin(ch, 1'b0);
                end
                chk("prescale early", 32'h0, {31'h0, irq_flag[ch]});
                pin(ch, 1'b1);
                pin(ch, 1'b0);
                chk("prescale hit", 32'h1, {31'h0, irq_flag[ch]});
            end
            // Compare modes in turn against value 0x0140
            acc(1'b1, lo[ch], 8'h40);
            acc(1'b1, hi[ch], 8'h01);
            setw(16'h0000);
            for (int i = 0; i < 5; i++) begin
                acc(1'b1, ctl[ch], {4'h0, cm[i]});
                acc(1'b1, IDX_FLAGS, 8'h03);
                c0 = clr_n;
                a0 = adc_n;
                setw(16'h0140);
                repeat (3) @(posedge ref_clk);
                setw(16'h0000);
                repeat (3) @(posedge ref_clk);
                chk("compare pin", {31'h0, cp[i]}, {31'h0, pin_out[ch]});
                chk("compare flag", 32'h1, {31'h0, irq_flag[ch]});
                chk("pin drive", 32'h0, {31'h0, pin_oe_n[ch]});
                chk("clear pulses", 32'(cm[i] == MODE_CMP_SPEC), 32'(clr_n - c0));
                chk("adc pulses", 32'(cm[i] == MODE_CMP_SPEC && ch == 1), 32'(adc_n - a0));
            end
            acc(1'b1, ctl[ch], 8'h00);
            repeat (2) @(posedge ref_clk);
            chk("pin after off", 32'h0, {31'h0, pin_out[ch]});
        end
        close_out();
    end
endmodule
